// >>> tws_ctrl_model.sv
module tws_ctrl_model (
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   timeunit 1ns;
   timeprecision 1ps;

   // ---------------------------------------------------------------
   // idle bus: clock parked high, data released to the pull-up
   // ---------------------------------------------------------------
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // ---------------------------------------------------------------
   // bit level, 1 us per bit, 600 ns low and 400 ns high
   // ---------------------------------------------------------------
   // change 150 ns into the 600 ns low phase so the device's own release lands first
   task automatic put_bit(input logic b, output logic r);
      #150 sda_low <= ~b;
      #450 scl <= 1'b1;
      #200 r = sda;
      #200 scl <= 1'b0;
   endtask

   // also serves as repeated start when entered with the clock low
   task automatic send_start();
      #150 sda_low <= 1'b0;
      #450 scl <= 1'b1;
      #300 sda_low <= 1'b1;
      #300 scl <= 1'b0;
   endtask

   task automatic send_stop();
      #150 sda_low <= 1'b1;
      #450 scl <= 1'b1;
      #300 sda_low <= 1'b0;
      #500;
   endtask

   // ---------------------------------------------------------------
   // byte level, msb first, ack on the ninth clock
   // ---------------------------------------------------------------
   task automatic put_byte(input logic [7:0] d, output logic ack);
      for (int i = 7; i >= 0; i--) put_bit(d[i], ack);
      put_bit(1'b1, ack);
   endtask

   // ack high means last byte; the caller then issues a stop
   task automatic get_byte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
      put_bit(ack, r);
   endtask
endmodule

// >>> tws_eeprom_slave.sv
module tws_eeprom_slave
   import tws_pkg::*;
#(
   parameter logic [3:0] TYPE_CODE = TYPE_CODE_DFLT,
   parameter int PROG_CYC = PROG_CYCLES
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic scl_pin,
   input wire logic sda_pin,
   output logic sda_o,
   output logic sda_oe,
   input wire logic wp_pin,
   input wire logic strap_select_low,
   input wire logic strap_select_high,
   output logic [ADDR_W-1:0] mem_addr,
   output logic mem_wr,
   output logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata,
   output logic prog_busy
);
   // ---------------------------------------------------------------
   // parameter checks
   // ---------------------------------------------------------------
   // the page walk needs 257 cycles inside the program window
   if (PROG_CYC < 260) begin : g_chk
      $error("PROG_CYC too small for the page walk");
   end

   localparam int TMR_W = $clog2(PROG_CYC + 1);
   localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(PROG_CYC - 1);

   // ---------------------------------------------------------------
   // pin front end
   // ---------------------------------------------------------------
   tws_line_if ln();

   tws_pin_sync u_sync (
      .mclk(mclk),
      .resetn(resetn),
      .scl_pin(scl_pin),
      .sda_pin(sda_pin),
      .wp_pin(wp_pin),
      .strap_pin({strap_select_high, strap_select_low}),
      .ln(ln)
   );

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   tws_state_t state_ff;
   tws_kind_t kind_ff;
   logic [3:0] cnt_ff;
   logic [7:0] sh_ff;
   logic [7:0] tx_ff;
   logic rw_ff;
   logic ack_got_ff;
   logic got_data_ff;
   logic [ADDR_W-1:0] addr_ff;
   logic sda_oe_ff;
   logic sda_o_ff;
   logic [7:0] page_buf [256];
   logic [255:0] vld_ff;
   logic [8:0] idx_ff;
   logic [TMR_W-1:0] tmr_ff;
   logic [ADDR_W-1:0] mem_addr_ff;
   logic mem_wr_ff;
   logic [7:0] mem_wdata_ff;
   logic prog_busy_ff;

   logic byte_end;
   logic dev_match;
   logic wr_store;
   logic tx_end;
   logic prog_go;
   logic [7:0] page_offset_bits;
   logic top_memory_address_bit;

   assign page_offset_bits = addr_ff[7:0];
   assign top_memory_address_bit = addr_ff[16];
   assign byte_end = ln.scl_fall && state_ff == ST_RX && cnt_ff == BIT_LAST;
   assign dev_match = sh_ff[7:DW_TYPE_LSB] == TYPE_CODE &&
      sh_ff[DW_TYPE_LSB-1:DW_STRAP_LSB] == ln.strap;
   assign wr_store = byte_end && kind_ff == K_DATA;
   assign tx_end = ln.scl_fall && state_ff == ST_TX && cnt_ff == BIT_LAST;
   // wp is sampled at the stop, so it must hold until then
   assign prog_go = ln.stop && state_ff != ST_PROG && !rw_ff &&
      got_data_ff && !ln.wp;

   // ---------------------------------------------------------------
   // transaction sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         state_ff <= ST_IDLE;
         kind_ff <= K_DEV;
      end else if (state_ff == ST_PROG) begin
         if (tmr_ff == TMR_LAST) begin
            state_ff <= ST_IDLE;
         end
      end else if (ln.start) begin
         state_ff <= ST_RX;
         kind_ff <= K_DEV;
      end else if (prog_go) begin
         state_ff <= ST_PROG;
      end else if (ln.stop) begin
         state_ff <= ST_IDLE;
      end else if (ln.scl_fall) begin
         case (state_ff)
            ST_RX: begin
               if (cnt_ff == BIT_LAST) begin
                  if (kind_ff != K_DEV || dev_match) begin
                     state_ff <= ST_ACK;
                  end else begin
                     state_ff <= ST_IDLE;
                  end
               end
            end
            ST_ACK: begin
               if (rw_ff && kind_ff == K_DEV) begin
                  state_ff <= ST_TX;
               end else begin
                  state_ff <= ST_RX;
                  if (kind_ff != K_DATA) begin
                     kind_ff <= tws_kind_t'(kind_ff + 2'h1);
                  end
               end
            end
            ST_TX: begin
               if (cnt_ff == BIT_LAST) begin
                  state_ff <= ST_TXACK;
               end
            end
            ST_TXACK: begin
               state_ff <= ack_got_ff ? ST_TX : ST_WAIT;
            end
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // bit counter and receive shifter
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!resetn || ln.start) begin
         cnt_ff <= 4'h0;
      end else if (ln.scl_rise && (state_ff == ST_RX ||
                                   state_ff == ST_TX)) begin
         cnt_ff <= cnt_ff + 4'h1;
      end else if (ln.scl_fall && cnt_ff == BIT_LAST) begin
         cnt_ff <= 4'h0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         sh_ff <= 8'h00;
      end else if (ln.scl_rise && state_ff == ST_RX) begin
         sh_ff <= {sh_ff[6:0], ln.sda};
      end
   end

   // ---------------------------------------------------------------
   // direction and read acknowledge
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         rw_ff <= 1'b0;
      end else if (byte_end && kind_ff == K_DEV && dev_match) begin
         rw_ff <= sh_ff[DW_RW];
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         ack_got_ff <= 1'b0;
      end else if (ln.scl_rise && state_ff == ST_TXACK) begin
         ack_got_ff <= ~ln.sda;
      end
   end

   // ---------------------------------------------------------------
   // address counter
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         addr_ff <= '0;
      end else if (byte_end) begin
         case (kind_ff)
            K_DEV: begin
               if (dev_match && !sh_ff[DW_RW]) begin
                  addr_ff[16] <= sh_ff[DW_A16];
               end
            end
            K_AHI: addr_ff[15:8] <= sh_ff;
            K_ALO: addr_ff[7:0] <= sh_ff;
            // only the offset moves, so the page wraps on itself
            K_DATA: addr_ff[7:0] <= addr_ff[7:0] + 8'h01;
            default: ;
         endcase
      end else if (tx_end) begin
         addr_ff <= addr_ff + 17'h00001;
      end
   end

   // ---------------------------------------------------------------
   // page buffer
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (wr_store) begin
         page_buf[page_offset_bits] <= sh_ff;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         vld_ff <= '0;
         got_data_ff <= 1'b0;
      end else if (ln.start && state_ff != ST_PROG) begin
         vld_ff <= '0;
         got_data_ff <= 1'b0;
      end else if (state_ff == ST_PROG) begin
         got_data_ff <= 1'b0;
      end else if (wr_store) begin
         vld_ff[page_offset_bits] <= 1'b1;
         got_data_ff <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // open-drain data driver
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         sda_oe_ff <= 1'b0;
      end else if (ln.start || ln.stop || state_ff == ST_PROG) begin
         sda_oe_ff <= 1'b0;
      end else if (ln.scl_fall) begin
         if (byte_end) begin
            sda_oe_ff <= kind_ff != K_DEV || dev_match;
         end else if (state_ff == ST_ACK && rw_ff && kind_ff == K_DEV) begin
            sda_oe_ff <= ~mem_rdata[7];
         end else if (state_ff == ST_TX && cnt_ff != BIT_LAST) begin
            sda_oe_ff <= ~tx_ff[6];
         end else if (state_ff == ST_TXACK && ack_got_ff) begin
            sda_oe_ff <= ~mem_rdata[7];
         end else begin
            sda_oe_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         tx_ff <= 8'h00;
      end else if (ln.scl_fall) begin
         if ((state_ff == ST_ACK && rw_ff && kind_ff == K_DEV) ||
             (state_ff == ST_TXACK && ack_got_ff)) begin
            tx_ff <= mem_rdata;
         end else if (state_ff == ST_TX) begin
            tx_ff <= {tx_ff[6:0], 1'b0};
         end
      end
   end

   // never drives high; the pull-up makes the ones
   always_ff @(posedge mclk) begin
      sda_o_ff <= 1'b0;
   end

   // ---------------------------------------------------------------
   // self-timed program cycle
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!resetn || state_ff != ST_PROG) begin
         tmr_ff <= '0;
         idx_ff <= 9'h000;
         mem_wr_ff <= 1'b0;
      end else begin
         tmr_ff <= tmr_ff + TMR_W'(1);
         mem_wr_ff <= 1'b0;
         if (!idx_ff[8]) begin
            idx_ff <= idx_ff + 9'h001;
            mem_wr_ff <= vld_ff[idx_ff[7:0]];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         mem_addr_ff <= '0;
         mem_wdata_ff <= 8'h00;
         prog_busy_ff <= 1'b0;
      end else begin
         prog_busy_ff <= state_ff == ST_PROG;
         if (state_ff == ST_PROG) begin
            mem_addr_ff <= {top_memory_address_bit, addr_ff[15:8],
                            idx_ff[7:0]};
            mem_wdata_ff <= page_buf[idx_ff[7:0]];
         end else begin
            mem_addr_ff <= addr_ff;
         end
      end
   end

   assign sda_o = sda_o_ff;
   assign sda_oe = sda_oe_ff;
   assign mem_addr = mem_addr_ff;
   assign mem_wr = mem_wr_ff;
   assign mem_wdata = mem_wdata_ff;
   assign prog_busy = prog_busy_ff;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   property p_open_drain;
      sda_oe_ff |-> (state_ff inside {ST_ACK, ST_TX}) && sda_o == 1'b0;
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("line pulled outside ack or read data");

   property p_drive_on_fall;
      $rose(sda_oe_ff) |-> $past(ln.scl_fall);
   endproperty
   a_drive_on_fall: assert property (p_drive_on_fall)
      else $error("pull-down began away from a clock fall");

   property p_no_match;
      byte_end && kind_ff == K_DEV && !dev_match && !ln.start && !ln.stop
         |=> state_ff == ST_IDLE && !sda_oe_ff;
   endproperty
   a_no_match: assert property (p_no_match)
      else $error("foreign address word was acknowledged");

   property p_write_ack;
      byte_end && (kind_ff != K_DEV || dev_match) && !ln.start && !ln.stop
         |=> state_ff == ST_ACK && sda_oe_ff;
   endproperty
   a_write_ack: assert property (p_write_ack)
      else $error("received byte not acknowledged");

   property p_prog_quiet;
      state_ff == ST_PROG |-> !sda_oe_ff;
   endproperty
   a_prog_quiet: assert property (p_prog_quiet)
      else $error("line driven during programming");

   property p_prog_go;
      prog_go && !ln.start |=> state_ff == ST_PROG ##1 prog_busy;
   endproperty
   a_prog_go: assert property (p_prog_go)
      else $error("stop after data did not start programming");

   property p_wp_block;
      ln.stop && ln.wp && state_ff != ST_PROG |=> state_ff != ST_PROG;
   endproperty
   a_wp_block: assert property (p_wp_block)
      else $error("programming started while protected");

   property p_prog_len;
      state_ff == ST_PROG |-> tmr_ff <= TMR_LAST;
   endproperty
   a_prog_len: assert property (p_prog_len)
      else $error("program cycle ran too long");

   property p_page_wrap;
      wr_store && addr_ff[7:0] == 8'hff |=> addr_ff[7:0] == 8'h00 &&
         addr_ff[16:8] == $past(addr_ff[16:8]);
   endproperty
   a_page_wrap: assert property (p_page_wrap)
      else $error("page offset did not wrap inside page");

   property p_seq_inc;
      tx_end |=> addr_ff == $past(addr_ff) + 17'h00001;
   endproperty
   a_seq_inc: assert property (p_seq_inc)
      else $error("read address did not advance by one");

   property p_nack_quiet;
      state_ff == ST_WAIT |-> !sda_oe_ff;
   endproperty
   a_nack_quiet: assert property (p_nack_quiet)
      else $error("line driven after read without ack");
endmodule

// >>> tws_eeprom_slave_tb_top.sv
module tws_eeprom_slave_tb_top
   import tws_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ---------------------------------------------------------------
   // setup
   // ---------------------------------------------------------------
   // arbitrary type code, not a real part's
   localparam logic [3:0] TC = 4'h9;
   // short program cycle keeps the run brief
   localparam int PCYC = 300;
   logic mclk = 1'b0;
   logic resetn, wp_pin, s_hi, s_lo, sda_o, sda_oe, mem_wr, prog_busy;
   logic scl, sda_low, sda, ack;
   logic [ADDR_W-1:0] mem_addr;
   logic [7:0] mem_wdata, mem_rdata, d;
   logic [7:0] mem [0:(1<<ADDR_W)-1];
   int num_errors, cmp_count, busy_cyc, b0;
   logic sda_o_bad = 1'b0;

   always #25 mclk = ~mclk;
   // open drain: low if anyone pulls, else the pull-up wins
   assign sda = (sda_oe | sda_low) ? 1'b0 : 1'b1;
   assign mem_rdata = mem[mem_addr];
   always @(posedge mclk) begin
      if (mem_wr === 1'b1) mem[mem_addr] <= mem_wdata;
      if (prog_busy === 1'b1) busy_cyc <= busy_cyc + 1;
      if (sda_oe === 1'b1 && sda_o !== 1'b0) sda_o_bad <= 1'b1;
   end

   tws_eeprom_slave #(.TYPE_CODE(TC), .PROG_CYC(PCYC)) i_tws_eeprom_slave (
      .mclk(mclk), .resetn(resetn), .scl_pin(scl), .sda_pin(sda),
      .sda_o(sda_o), .sda_oe(sda_oe), .wp_pin(wp_pin),
      .strap_select_low(s_lo), .strap_select_high(s_hi),
      .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .prog_busy(prog_busy));
   tws_ctrl_model i_tws_ctrl_model (.scl(scl), .sda_low(sda_low),
      .sda(sda));

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic final_report();
      $display("compares %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic dev_word(input logic rw, input logic a16, input logic e);
      i_tws_ctrl_model.send_start();
      i_tws_ctrl_model.put_byte({TC, s_hi, s_lo, a16, rw}, ack);
      chk("addr word ack", 8'(e), 8'(ack));
   endtask

   task automatic wr_byte(input logic [7:0] v);
      i_tws_ctrl_model.put_byte(v, ack);
      chk("write ack", 8'h0, 8'(ack));
   endtask

   task automatic set_addr(input logic [16:0] a);
      dev_word(1'b0, a[16], 1'b0);
      wr_byte(a[15:8]);
      wr_byte(a[7:0]);
   endtask

   task automatic rd_chk(input logic a, input logic [7:0] e);
      i_tws_ctrl_model.get_byte(a, d);
      chk("read data", e, d);
   endtask

   // bounded at 400 cycles; a hang here ends the run as a failure
   task automatic wait_prog();
      int n;
      n = 0;
      while (prog_busy !== 1'b0 && n < 400) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 400) begin
         num_errors++;
         $display("MISMATCH prog_busy expected 0 seen 1");
         final_report();
      end
   endtask

   // ---------------------------------------------------------------
   // sequence
   // ---------------------------------------------------------------
   initial begin
      resetn = 1'b0;
      wp_pin = 1'b0;
      s_hi = 1'b1;
      s_lo = 1'b0;
      busy_cyc = 0;
      num_errors = 0;
      cmp_count = 0;
      mem[17'h12400] = 8'h5a;
      mem[17'h12401] = 8'h96;
      mem[17'h1ffff] = 8'hc3;
      mem[17'h00000] = 8'h3c;
      mem[17'h00001] = 8'he1;
      mem[17'h00010] = 8'h11;
      repeat (20) @(posedge mclk);
      chk("sda_oe in reset", 8'h0, 8'(sda_oe));
      chk("prog_busy in reset", 8'h0, 8'(prog_busy));
      resetn <= 1'b1;
      repeat (4) @(posedge mclk);
      // foreign words: straps flipped, then type code flipped
      i_tws_ctrl_model.send_start();
      i_tws_ctrl_model.put_byte({TC, ~s_hi, s_lo, 2'b00}, ack);
      chk("strap mismatch ack", 8'h1, 8'(ack));
      i_tws_ctrl_model.send_start();
      i_tws_ctrl_model.put_byte({TC, s_hi, ~s_lo, 2'b00}, ack);
      chk("low strap mismatch ack", 8'h1, 8'(ack));
      i_tws_ctrl_model.send_start();
      i_tws_ctrl_model.put_byte({~TC, s_hi, s_lo, 2'b00}, ack);
      chk("type mismatch ack", 8'h1, 8'(ack));
      i_tws_ctrl_model.send_stop();
      // page write running over the end of the page
      set_addr(17'h123fe);
      wr_byte(8'ha1);
      wr_byte(8'ha2);
      wr_byte(8'ha3);
      b0 = busy_cyc;
      i_tws_ctrl_model.send_stop();
      @(posedge mclk);
      chk("busy after stop", 8'h1, 8'(prog_busy));
      dev_word(1'b0, 1'b1, 1'b1);
      i_tws_ctrl_model.send_stop();
      wait_prog();
      chk("program length", 8'h1, 8'(busy_cyc - b0 <= PCYC + 1 &&
          busy_cyc - b0 >= PCYC - 1));
      dev_word(1'b0, 1'b1, 1'b0);
      i_tws_ctrl_model.send_stop();
      repeat (20) @(posedge mclk);
      chk("no program on empty write", 8'h0, 8'(prog_busy));
      chk("page byte fe", 8'ha1, mem[17'h123fe]);
      chk("page byte ff", 8'ha2, mem[17'h123ff]);
      chk("wrapped byte 00", 8'ha3, mem[17'h12300]);
      // protected write is acked but never programmed
      wp_pin <= 1'b1;
      set_addr(17'h00010);
      wr_byte(8'h77);
      i_tws_ctrl_model.send_stop();
      repeat (20) @(posedge mclk);
      chk("busy with wp", 8'h0, 8'(prog_busy));
      chk("protected byte", 8'h11, mem[17'h00010]);
      // random read across a page boundary, still protected
      set_addr(17'h123ff);
      dev_word(1'b1, 1'b0, 1'b0);
      rd_chk(1'b0, 8'ha2);
      rd_chk(1'b0, 8'h5a);
      rd_chk(1'b1, 8'h96);
      i_tws_ctrl_model.put_bit(1'b1, ack);
      chk("released after nack", 8'h1, 8'(ack));
      i_tws_ctrl_model.put_bit(1'b1, ack);
      chk("still released", 8'h1, 8'(ack));
      i_tws_ctrl_model.send_stop();
      wp_pin <= 1'b0;
      // read wrapping from the last location to zero
      set_addr(17'h1ffff);
      dev_word(1'b1, 1'b0, 1'b0);
      rd_chk(1'b0, 8'hc3);
      rd_chk(1'b1, 8'h3c);
      i_tws_ctrl_model.send_stop();
      // current address read after standby
      dev_word(1'b1, 1'b1, 1'b0);
      rd_chk(1'b1, 8'he1);
      i_tws_ctrl_model.send_stop();
      repeat (10) @(posedge mclk);
      chk("sda_o while pulling", 8'h0, 8'(sda_o_bad));
      final_report();
   end

   // hard stop in case the link tasks never return
   initial begin
      #3ms;
      num_errors++;
      $display("MISMATCH run time expected done seen hang");
      final_report();
   end
endmodule

// >>> tws_line_if.sv
interface tws_line_if;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   logic sda;
   logic wp;
   logic [1:0] strap;
   modport src(output scl_rise, scl_fall, start, stop, sda, wp, strap);
   modport snk(input scl_rise, scl_fall, start, stop, sda, wp, strap);
endinterface

// >>> tws_pin_sync.sv
module tws_pin_sync
   import tws_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic scl_pin,
   input wire logic sda_pin,
   input wire logic wp_pin,
   input wire logic [1:0] strap_pin,
   tws_line_if.src ln
);
   // ---------------------------------------------------------------
   // two-stage synchronisers, one per pin
   // ---------------------------------------------------------------
   logic [4:0] pin_w;
   logic [4:0] sync_w;
   logic scl_q_ff;
   logic sda_q_ff;

   assign pin_w = {strap_pin, wp_pin, sda_pin, scl_pin};

   for (genvar i = 0; i < 5; i++) begin : g_sync
      logic s1_ff;
      logic s2_ff;
      always_ff @(posedge mclk) begin
         if (!resetn) begin
            s1_ff <= SYNC_RST[i];
            s2_ff <= SYNC_RST[i];
         end else begin
            s1_ff <= pin_w[i];
            s2_ff <= s1_ff;
         end
      end
      assign sync_w[i] = s2_ff;
   end

   // ---------------------------------------------------------------
   // edge and condition detection
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
      end else begin
         scl_q_ff <= sync_w[0];
         sda_q_ff <= sync_w[1];
      end
   end

   assign ln.scl_rise = sync_w[0] & ~scl_q_ff;
   assign ln.scl_fall = ~sync_w[0] & scl_q_ff;
   // both need scl high before and after, so a clock edge never counts
   assign ln.start = sync_w[0] & scl_q_ff & sda_q_ff & ~sync_w[1];
   assign ln.stop = sync_w[0] & scl_q_ff & ~sda_q_ff & sync_w[1];
   assign ln.sda = sync_w[1];
   assign ln.wp = sync_w[2];
   assign ln.strap = sync_w[4:3];
endmodule

// >>> tws_pkg.sv
package tws_pkg;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ = 20_000_000;
   localparam real PROG_TIME_MS = 5.0;
   // longest time: round down
   localparam int PROG_CYCLES = int'($floor(PROG_TIME_MS * CLK_HZ / 1000.0));
   // ---------------------------------------------------------------
   // address word layout
   // ---------------------------------------------------------------
   localparam int ADDR_W = 17;
   localparam int DW_TYPE_LSB = 4;
   localparam int DW_STRAP_LSB = 2;
   localparam int DW_A16 = 1;
   localparam int DW_RW = 0;
   // arbitrary type code, not a real part's
   localparam logic [3:0] TYPE_CODE_DFLT = 4'h6;
   localparam logic [3:0] BIT_LAST = 4'h8;
   localparam logic [4:0] SYNC_RST = 5'h03;
   typedef enum logic [2:0] {
      ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK, ST_WAIT, ST_PROG
   } tws_state_t;
   typedef enum logic [1:0] {K_DEV, K_AHI, K_ALO, K_DATA} tws_kind_t;
endpackage
